// ===== bench/imc_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "imc_cfg.svh"
// ----------------------------------------
// port checker for the serial master
// ----------------------------------------
module imc_props #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // serial bus
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic divSmall_q;
  logic popSeen_q;
  logic [9:0] lowRun_q;
  // bus decodes; the bench always offers address and data together
  wire wrBoth = awvalid && awready && wvalid && wready;
  wire rdTake = arvalid && arready;
  wire rxdTake = rdTake && araddr == `IMC_OFS_RXD;
  wire [8:0] divSum = {1'b0, wdata[7:0]} + {1'b0, wdata[15:8]};
  // a low run past 300 cycles is longer than any phase, so it is a stretch
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      divSmall_q <= 1'b0;
      popSeen_q <= 1'b0;
      lowRun_q <= 10'h0;
    end else begin
      if (wrBoth && awaddr == `IMC_OFS_DIV) divSmall_q <= divSum < `IMC_MIN_DIV_SUM;
      popSeen_q <= sclOe && (popSeen_q || rxdTake);
      lowRun_q <= !sclOe ? 10'h0 : (lowRun_q == 10'h3ff ? lowRun_q : lowRun_q + 10'h1);
    end
  end
  a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before it was taken");
  a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before it was taken");
  a_unmapped_read: assert property (rdTake && araddr > `IMC_OFS_RXD |-> ##[1:3]
    (rvalid && rresp == `IMC_RESP_SLVERR && rdata == 32'h0))
    else $error("unmapped read not answered with an error");
  a_mapped_read: assert property (rdTake && araddr <= `IMC_OFS_RXD && araddr[1:0] == 2'h0
    && araddr != `IMC_OFS_CMD
    |-> ##[1:3] (rvalid && rresp == `IMC_RESP_OKAY))
    else $error("mapped read not answered");
  a_write_answer: assert property (wrBoth |-> ##[1:3] bvalid)
    else $error("write not answered");
  a_read_refused: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  a_small_div_idle: assert property (divSmall_q && !sdaOe && !sclOe |=> !sdaOe && !sclOe)
    else $error("transfer started with a too small divider");
  a_stretch_waits: assert property (sclOe && lowRun_q >= 10'd300 && !popSeen_q && !rxdTake
    |=> sclOe)
    else $error("clock released during a stretch without a read");
  a_stretch_resumes: assert property (lowRun_q >= 10'd300 && rxdTake |-> ##[1:600] !sclOe)
    else $error("transfer did not resume after a read");
  cover property (rxdTake && lowRun_q >= 10'd300);
  cover property (divSmall_q && wrBoth && awaddr == `IMC_OFS_CMD);
  cover property (rdTake && araddr > `IMC_OFS_RXD);
endmodule // imc_props
bind imc_top imc_props #(.DEPTH(DEPTH)) u_imc_props (.ref_clk(ref_clk), .srst(srst),
  .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
  .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .rresp(rresp), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));
`default_nettype wire

// ===== bench/imc_target.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// serial target answering reads with a rising byte count
// ----------------------------------------
module imc_target #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // open drain lines, resolved by the bench
  input wire logic scl,
  input wire logic sda,
  // pull data low
  output logic sdaOe
);
  logic [7:0] shift;
  logic [7:0] nxt;
  logic ack;
  // data moves only while the clock is low, so no start or stop is faked
  initial begin
    sdaOe = 1'b0;
    nxt = 8'ha0;
    forever begin
      @(negedge sda iff scl === 1'b1);
      for (int i = 0; i < 8; i++) begin
        @(posedge scl);
        shift = {shift[6:0], sda};
      end
      @(negedge scl);
      if (shift == {ADDR, 1'b1}) begin
        sdaOe = 1'b1;
        @(negedge scl);
        do begin
          for (int i = 7; i >= 0; i--) begin
            sdaOe = !nxt[i];
            @(negedge scl);
          end
          sdaOe = 1'b0;
          @(posedge scl);
          ack = !sda;
          nxt++;
          if (ack) @(negedge scl);
        end while (ack);
      end
    end
  end
endmodule // imc_target
`default_nettype wire

// ===== bench/tb_i2c_master_clock_and_rx_overflow.sv
`timescale 1ns/100ps
`default_nettype none
`include "imc_cfg.svh"
module tb_i2c_master_clock_and_rx_overflow;
  // ----------------------------------------
  // clock, bus and serial lines
  // ----------------------------------------
  localparam logic [6:0] TADDR = 7'h2a;
  logic ref_clk, srst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, sclOut, sclOe, sdaOut, sdaOe, tgtSdaOe;
  logic [7:0] awaddr, araddr, expByte;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  wire scl, sda;
  int mismatches, n_compared, sclRises;
  // pulled up unless someone pulls low
  assign scl = !sclOe;
  assign sda = !(sdaOe || tgtSdaOe);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = !ref_clk;
  end
  always @(posedge scl) sclRises++;
  imc_top #(.DEPTH(16)) u_imc_top (.ref_clk(ref_clk), .srst(srst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe));
  imc_target #(.ADDR(TADDR)) u_imc_target (.scl(scl), .sda(sda), .sdaOe(tgtSdaOe));
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask
  // a used-up wait ends the run at once
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      $display("unexpected wait: limit %0d used up", lim);
      print_verdict();
    end
  endtask
  // ready and response channels are sampled at the same edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && n < 100);
    bound(n, 100);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    arvalid <= 1'b1;
    araddr <= a;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && n < 100);
    bound(n, 100);
    v = rdata;
    r = rresp;
  endtask
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      rd(`IMC_OFS_STAT);
      n++;
    end while (v[b] !== 1'b1 && n < 3000);
    bound(n, 3000);
  endtask
  // start an n byte read, optionally wait, then collect every byte in order
  task automatic xfer(input int nb, input int rise, input int gap, input bit hold);
    int n, got;
    wr(`IMC_OFS_STAT, 32'h7f);
    sclRises = 0;
    wr(`IMC_OFS_CMD, {16'h0, nb[7:0], 1'b0, TADDR});
    n = 0;
    while (sclRises < rise && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    bound(n, 20000);
    repeat (gap) @(posedge ref_clk);
    if (hold) begin
      poll(`IMC_STAT_HOLD);
      chk("overflow flag", 32'(v[`IMC_STAT_OVF]), 32'h1);
    end
    got = 0;
    n = 0;
    while (got < nb && n < 5000) begin
      rd(`IMC_OFS_RXD);
      n++;
      if (v[8] === 1'b1) begin
        chk("received byte", 32'(v[7:0]), 32'(expByte));
        expByte++;
        got++;
      end
    end
    bound(n, 5000);
    poll(`IMC_STAT_DONE);
    $display("test read of %0d bytes, gap %0d done", nb, gap);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    expByte = 8'ha0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    // reset values and an unmapped place
    rd(`IMC_OFS_CTRL);
    chk("ctrl reset", v, 32'h2);
    rd(`IMC_OFS_DIV);
    chk("div reset", v, 32'h0a0a);
    rd(8'h14);
    chk("unmapped read resp", 32'(r), 32'h2);
    chk("unmapped read data", v, 32'h0);
    wr(8'h14, 32'h0);
    chk("unmapped write resp", 32'(r), 32'h2);
    $display("test registers done");
    // a divider sum one below the limit is refused and no clock appears
    wr(`IMC_OFS_DIV, 32'h0708);
    sclRises = 0;
    wr(`IMC_OFS_CMD, {16'h0, 8'h02, 1'b0, TADDR});
    repeat (300) @(posedge ref_clk);
    rd(`IMC_OFS_STAT);
    chk("start refused", 32'(v[`IMC_STAT_REJ]), 32'h1);
    chk("divider flag", 32'(v[`IMC_STAT_DIVERR]), 32'h1);
    chk("clock edges", 32'(sclRises), 32'h0);
    wr(`IMC_OFS_DIV, 32'h0808);
    rd(`IMC_OFS_STAT);
    chk("divider flag at limit", 32'(v[`IMC_STAT_DIVERR]), 32'h0);
    $display("test divider limit done");
    // a target address nobody answers ends in a stop with the nack flag
    wr(`IMC_OFS_STAT, 32'h7f);
    wr(`IMC_OFS_CMD, {16'h0, 8'h02, 1'b0, 7'h15});
    poll(`IMC_STAT_DONE);
    chk("address nack", 32'(v[`IMC_STAT_NACK]), 32'h1);
    chk("idle after nack", 32'(v[`IMC_STAT_BUSY]), 32'h0);
    $display("test address nack done");
    // fifo fills, the clock is held until reads free room
    xfer(20, 0, 0, 1'b1);
    // reads placed around the moment the seventeenth byte completes
    for (int g = 0; g < 24; g += 4) begin
      xfer(20, 161, g, 1'b0);
    end
    // without stretching the bytes past a full fifo are dropped
    wr(`IMC_OFS_CTRL, 32'h0);
    wr(`IMC_OFS_STAT, 32'h7f);
    wr(`IMC_OFS_CMD, {16'h0, 8'd18, 1'b0, TADDR});
    poll(`IMC_STAT_DONE);
    chk("overflow no stretch", 32'(v[`IMC_STAT_OVF]), 32'h1);
    for (int i = 0; i < 16; i++) begin
      rd(`IMC_OFS_RXD);
      chk("kept byte", 32'(v[8:0]), {23'h0, 1'b1, expByte});
      expByte++;
    end
    rd(`IMC_OFS_RXD);
    chk("fifo empty", 32'(v[8]), 32'h0);
    $display("test overflow without stretch done");
    print_verdict();
  end
endmodule // tb_i2c_master_clock_and_rx_overflow
`default_nettype wire

// ===== design/imc_cfg.svh
`ifndef IMC_CFG_SVH
`define IMC_CFG_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define IMC_OFS_CTRL 8'h00
`define IMC_OFS_DIV 8'h04
`define IMC_OFS_CMD 8'h08
`define IMC_OFS_STAT 8'h0c
`define IMC_OFS_RXD 8'h10
// ----------------------------------------
// field positions
// ----------------------------------------
`define IMC_CTRL_STRETCH 1
`define IMC_STAT_BUSY 0
`define IMC_STAT_OVF 1
`define IMC_STAT_NACK 2
`define IMC_STAT_DIVERR 3
`define IMC_STAT_HOLD 4
`define IMC_STAT_REJ 5
`define IMC_STAT_DONE 6
`define IMC_RXD_VALID 8
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define IMC_RST_CTRL 2'h2
`define IMC_RST_LOW 8'h0a
`define IMC_RST_HIGH 8'h0a
`define IMC_MIN_DIV_SUM 9'h010
`define IMC_RESP_OKAY 2'h0
`define IMC_RESP_SLVERR 2'h2
`endif

// ===== design/imc_div.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// phase timer for the serial clock
// ----------------------------------------
module imc_div #(
  parameter int CW = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // control
  input wire logic run,
  input wire logic selHigh,
  input wire logic [CW-1:0] lowCnt,
  input wire logic [CW-1:0] highCnt,
  // phase end, one cycle
  output logic done
);
  logic [CW-1:0] cnt_q;
  wire [CW-1:0] target = selHigh ? highCnt : lowCnt;
  // a zero count still lasts one cycle
  assign done = run && (cnt_q + 1'b1 >= target);

  // restarts whenever the phase is paused or ends
  always_ff @(posedge ref_clk) begin
    if (srst || !run || done) cnt_q <= '0;
    else cnt_q <= cnt_q + 1'b1;
  end
endmodule // imc_div
`default_nettype wire

// ===== design/imc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// receive fifo, read data registered at pop
// ----------------------------------------
module imc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] level_q;
  logic [WIDTH-1:0] outData_q;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  // honest flags from the level counter
  assign inReady = (level_q != (AW+1)'(DEPTH));
  assign outValid = (level_q != '0);
  assign outData = outData_q;

  // pointers and level
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      level_q <= '0;
    end else begin
      if (push) wrPtr_q <= AW'((wrPtr_q + 1'b1) % DEPTH);
      if (pop) rdPtr_q <= AW'((rdPtr_q + 1'b1) % DEPTH);
      level_q <= level_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage; head copied out on pop
  always_ff @(posedge ref_clk) begin
    if (push) mem[wrPtr_q] <= inData;
    if (srst) outData_q <= '0;
    else if (pop) outData_q <= mem[rdPtr_q];
  end
endmodule // imc_fifo
`default_nettype wire

// ===== design/imc_pkg.sv
package imc_pkg;
  // serial engine states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_START = 8'h02,
    ST_BITLO = 8'h04,
    ST_BITHI = 8'h08,
    ST_HOLD = 8'h10,
    ST_STOPLO = 8'h20,
    ST_STOPHI = 8'h40,
    ST_STOPEND = 8'h80
  } imc_state_t;
endpackage

// ===== design/imc_top.sv
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "imc_cfg.svh"
module imc_top #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // serial bus, open drain
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // divider sum check, used for status and start gating
  function automatic logic divTooSmall(input logic [7:0] lo, input logic [7:0] hi);
    return ({1'b0, lo} + {1'b0, hi}) < `IMC_MIN_DIV_SUM;
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  imc_pkg::imc_state_t state_q, state_d;
  logic [1:0] ctrl_q;
  logic [7:0] lowCnt_q, highCnt_q;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic addrPhase_q, addrPhase_d;
  logic [7:0] left_q, left_d;
  logic [7:0] pend_q;
  logic awHeld_q, wHeld_q, rPend_q;
  logic [7:0] awAddr_q, arAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic ovf_q, nack_q, rej_q, done_q;
  logic sclS1_q, sclS2_q, sdaS1_q, sdaS2_q;
  logic divDone;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoPop;
  logic [7:0] fifoInData, fifoOutData;
  logic popTaken_q;
  logic evOvf, evNack, evDone;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // two flops before any logic reads the pins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sclS1_q <= 1'b1;
      sclS2_q <= 1'b1;
      sdaS1_q <= 1'b1;
      sdaS2_q <= 1'b1;
    end else begin
      sclS1_q <= sclIn;
      sclS2_q <= sclS1_q;
      sdaS1_q <= sdaIn;
      sdaS2_q <= sdaS1_q;
    end
  end

  // ----------------------------------------
  // register bus decode
  // ----------------------------------------
  wire doWrite = awHeld_q && wHeld_q && !bvalid;
  wire arTake = arvalid && arready;
  wire divErr = divTooSmall(lowCnt_q, highCnt_q);
  wire wrCtrl = doWrite && (awAddr_q == `IMC_OFS_CTRL) && wStrb_q[0];
  wire wrDiv = doWrite && (awAddr_q == `IMC_OFS_DIV);
  wire wrCmd = doWrite && (awAddr_q == `IMC_OFS_CMD) && wStrb_q[0];
  wire wrStat = doWrite && (awAddr_q == `IMC_OFS_STAT) && wStrb_q[0];
  wire wrHit = (awAddr_q == `IMC_OFS_CTRL) || (awAddr_q == `IMC_OFS_DIV)
    || (awAddr_q == `IMC_OFS_CMD) || (awAddr_q == `IMC_OFS_STAT);
  wire rdRxd = arTake && (araddr == `IMC_OFS_RXD);
  wire rdHit = (arAddr_q == `IMC_OFS_CTRL) || (arAddr_q == `IMC_OFS_DIV)
    || (arAddr_q == `IMC_OFS_STAT) || (arAddr_q == `IMC_OFS_RXD);
  // a start with a too small divider is refused instead of hanging the bus
  wire startOk = wrCmd && (state_q == imc_pkg::ST_IDLE) && !divErr;
  wire startRej = wrCmd && !startOk;
  wire stretchEn = ctrl_q[`IMC_CTRL_STRETCH];
  wire busy = (state_q != imc_pkg::ST_IDLE);
  wire holding = (state_q == imc_pkg::ST_HOLD);

  assign awready = !awHeld_q;
  assign wready = !wHeld_q;
  assign arready = !rPend_q && !rvalid;
  assign fifoPop = rdRxd && fifoOutValid;

  wire [31:0] statWord = {25'h0, done_q, rej_q, holding, divErr, nack_q, ovf_q, busy};

  // ----------------------------------------
  // write channel capture and response
  // ----------------------------------------
  // address and data are held separately, so either may come first
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `IMC_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrHit ? `IMC_RESP_OKAY : `IMC_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read channel, two cycles so popped data can settle
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rPend_q <= 1'b0;
      arAddr_q <= 8'h00;
      popTaken_q <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `IMC_RESP_OKAY;
    end else begin
      rPend_q <= arTake;
      if (arTake) begin
        arAddr_q <= araddr;
        popTaken_q <= fifoPop;
      end
      if (rPend_q) begin
        rvalid <= 1'b1;
        rresp <= rdHit ? `IMC_RESP_OKAY : `IMC_RESP_SLVERR;
        unique case (arAddr_q)
          `IMC_OFS_CTRL: rdata <= {30'h0, ctrl_q};
          `IMC_OFS_DIV: rdata <= {16'h0, highCnt_q, lowCnt_q};
          `IMC_OFS_STAT: rdata <= statWord;
          `IMC_OFS_RXD: rdata <= {23'h0, popTaken_q, fifoOutData};
          default: rdata <= 32'h0;
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= `IMC_RST_CTRL;
      lowCnt_q <= `IMC_RST_LOW;
      highCnt_q <= `IMC_RST_HIGH;
    end else begin
      if (wrCtrl) ctrl_q <= wData_q[1:0];
      if (wrDiv && wStrb_q[0]) lowCnt_q <= wData_q[7:0];
      if (wrDiv && wStrb_q[1]) highCnt_q <= wData_q[15:8];
    end
  end

  // ----------------------------------------
  // sticky status, write one to clear, set wins
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ovf_q <= 1'b0;
      nack_q <= 1'b0;
      rej_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      ovf_q <= evOvf || (ovf_q && !(wrStat && wData_q[`IMC_STAT_OVF]));
      nack_q <= evNack || (nack_q && !(wrStat && wData_q[`IMC_STAT_NACK]));
      rej_q <= startRej || (rej_q && !(wrStat && wData_q[`IMC_STAT_REJ]));
      done_q <= evDone || (done_q && !(wrStat && wData_q[`IMC_STAT_DONE]));
    end
  end

  // ----------------------------------------
  // phase timer and fifo
  // ----------------------------------------
  // high phases only count while the line really is high (target stretching)
  wire highPhase = (state_q == imc_pkg::ST_START) || (state_q == imc_pkg::ST_BITHI)
    || (state_q == imc_pkg::ST_STOPHI) || (state_q == imc_pkg::ST_STOPEND);
  wire divRun = busy && !holding && (!highPhase || sclS2_q);

  imc_div #(.CW(8)) uDiv (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(divRun),
    .selHigh(highPhase),
    .lowCnt(lowCnt_q),
    .highCnt(highCnt_q),
    .done(divDone)
  );

  imc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) uFifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  wire [7:0] sampled = {shift_q[6:0], sdaS2_q};
  wire byteEnd = (state_q == imc_pkg::ST_BITHI) && divDone && !addrPhase_q
    && (bitCnt_q == 4'd7);
  wire ackEnd = (state_q == imc_pkg::ST_BITHI) && divDone && (bitCnt_q == 4'd8);
  // the byte goes straight in when there is room; else, with stretching on, it waits in pend_q,
  // so a read landing anywhere around the last bit cannot lose it
  assign fifoInValid = byteEnd || holding;
  assign fifoInData = holding ? pend_q : sampled;
  assign evOvf = byteEnd && !fifoInReady;
  assign evNack = ackEnd && addrPhase_q && sdaS2_q;
  assign evDone = (state_q == imc_pkg::ST_STOPEND) && divDone;

  // hold a byte that found the fifo full
  always_ff @(posedge ref_clk) begin
    if (srst) pend_q <= 8'h00;
    else if (byteEnd) pend_q <= sampled;
  end

  // next state
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bitCnt_d = bitCnt_q;
    addrPhase_d = addrPhase_q;
    left_d = left_q;
    unique case (state_q)
      imc_pkg::ST_IDLE: begin
        if (startOk) begin
          state_d = imc_pkg::ST_START;
          shift_d = {wData_q[6:0], 1'b1};
          left_d = wData_q[15:8];
          addrPhase_d = 1'b1;
          bitCnt_d = 4'd0;
        end
      end
      imc_pkg::ST_START: begin
        if (divDone) state_d = imc_pkg::ST_BITLO;
      end
      imc_pkg::ST_BITLO: begin
        if (divDone) state_d = imc_pkg::ST_BITHI;
      end
      imc_pkg::ST_BITHI: begin
        if (divDone) begin
          state_d = imc_pkg::ST_BITLO;
          bitCnt_d = bitCnt_q + 4'd1;
          shift_d = addrPhase_q ? {shift_q[6:0], 1'b1} : sampled;
          if (byteEnd && !fifoInReady && stretchEn) begin
            state_d = imc_pkg::ST_HOLD;
          end
          if (ackEnd) begin
            bitCnt_d = 4'd0;
            addrPhase_d = 1'b0;
            if (addrPhase_q && sdaS2_q) state_d = imc_pkg::ST_STOPLO;
            else if (!addrPhase_q) begin
              left_d = left_q - 8'd1;
              if (left_q <= 8'd1) state_d = imc_pkg::ST_STOPLO;
            end else if (left_q == 8'd0) state_d = imc_pkg::ST_STOPLO;
          end
        end
      end
      imc_pkg::ST_HOLD: begin
        if (fifoInReady) state_d = imc_pkg::ST_BITLO;
      end
      imc_pkg::ST_STOPLO: begin
        if (divDone) state_d = imc_pkg::ST_STOPHI;
      end
      imc_pkg::ST_STOPHI: begin
        if (divDone) state_d = imc_pkg::ST_STOPEND;
      end
      imc_pkg::ST_STOPEND: begin
        if (divDone) state_d = imc_pkg::ST_IDLE;
      end
      default: state_d = imc_pkg::ST_IDLE;
    endcase
  end

  // engine registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= imc_pkg::ST_IDLE;
      shift_q <= 8'h00;
      bitCnt_q <= 4'd0;
      addrPhase_q <= 1'b0;
      left_q <= 8'h00;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bitCnt_q <= bitCnt_d;
      addrPhase_q <= addrPhase_d;
      left_q <= left_d;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // lines are only ever pulled low; release means oe low
  wire lowPhase = (state_q == imc_pkg::ST_BITLO) || (state_q == imc_pkg::ST_STOPLO);
  wire ackDrive = !addrPhase_q && (left_q > 8'd1);
  wire bitDrive = addrPhase_q ? !shift_q[7] : 1'b0;
  wire dataSlot = (state_q == imc_pkg::ST_BITLO) || (state_q == imc_pkg::ST_BITHI);
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = lowPhase || holding;
  assign sdaOe = (state_q == imc_pkg::ST_START) || (state_q == imc_pkg::ST_STOPLO)
    || (state_q == imc_pkg::ST_STOPHI)
    || (dataSlot && ((bitCnt_q == 4'd8) ? ackDrive : bitDrive));
endmodule // imc_top
`default_nettype wire
